// *** design/cmsb_core.v ***
// connection word store, source decoder and big-endian message byte window
`timescale 1ns/100ps
`default_nettype none
`include "cmsb_regs.vh"

module cmsb_core #(
	parameter GRP_W = 5
)(
	input wire clk,
	input wire arst_n,
	input wire host_cs_n,
	input wire host_rw,
	input wire [1:0] host_size,
	input wire [23:0] host_addr,
	input wire [31:0] host_data_in,
	output reg [31:0] host_data_out,
	output reg host_data_oe,
	output reg host_ack_n,
	output reg bus_fault_n,
	input wire [(2<<GRP_W)-1:0] group_rate,
	input wire seq_req,
	input wire [GRP_W+9:0] seq_index,
	input wire seq_bit_en,
	output reg seq_valid,
	output reg [2:0] seq_function,
	output reg seq_connect,
	output reg seq_msg,
	output reg [9:0] seq_src_channel,
	output reg [1:0] seq_src_lane,
	output wire seq_msg_bit
);

// store depth and host cycle states
localparam DEPTH = 1024 << GRP_W;
localparam ST_IDLE = 2'h0;
localparam ST_CHECK = 2'h1;
localparam ST_XFER = 2'h2;
localparam ST_RESP = 2'h3;

// ****************************************
// decode functions
// ****************************************
// input channel number from the source field;
// lane bits drop off the bottom at lower rates
function [9:0] src_channel;
	input [1:0] rate;
	input [9:0] src;
	begin
		case (rate)
			`CMSB_RATE_65: src_channel = src;
			`CMSB_RATE_32: src_channel = {1'b0, src[9:1]};
			`CMSB_RATE_16: src_channel = {2'b00, src[9:2]};
			default: src_channel = {3'b000, src[9:3]};
		endcase
	end
endfunction

// input lane from the source field
// one lane only at 65 Mbps, so it reads lane a
function [1:0] src_lane;
	input [1:0] rate;
	input [9:0] src;
	begin
		case (rate)
			`CMSB_RATE_65: src_lane = 2'h0;
			`CMSB_RATE_32: src_lane = {1'b0, src[0]};
			default: src_lane = src[1:0];
		endcase
	end
endfunction

// rate of one output group
// two bits per group, group 0 at the bottom
function [1:0] rate_of;
	input [(2<<GRP_W)-1:0] vec;
	input [GRP_W-1:0] grp;
	begin
		rate_of = vec[{grp, 1'b0} +: 2];
	end
endfunction

// ****************************************
// storage
// ****************************************
// one connection word per output channel
reg [31:0] cmem [0:DEPTH-1];

// ****************************************
// host strobe synchroniser and capture
// ****************************************
// host request as captured once the synced strobe is low
reg cs_meta;
reg cs_sync;
reg [1:0] state;
reg [1:0] step;
reg [1:0] last_step;
reg cap_rw;
reg [1:0] cap_size;
reg [23:0] cap_addr;
reg [31:0] cap_data;
reg cap_win;
reg fault;

// two flops on the chip select; only the strobe is synced,
// so address, size and data must stand while it is low
always @(posedge clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		cs_meta <= 1'b1;
		cs_sync <= 1'b1;
	end
	else
	begin
		cs_meta <= host_cs_n;
		cs_sync <= cs_meta;
	end
end

// ****************************************
// address decode
// ****************************************
// group and offset of a window access; the word region
// takes whole words only, and the upper half of an
// 8 Mbps group window has no stream behind it
wire [GRP_W-1:0] win_grp = cap_addr[GRP_W+9:10];
wire [9:0] win_off = cap_addr[9:0];
wire [1:0] win_rate = rate_of(group_rate, win_grp);
wire in_word = (cap_addr[23:17] == 7'h00);
wire in_win = (cap_addr >= `CMSB_WIN_BASE) &&
	(cap_addr <= `CMSB_WIN_LAST);
wire upper_off = (win_rate == `CMSB_RATE_8) && win_off[9];
wire misalign = ((cap_size == `CMSB_SIZE_HALF) && cap_addr[0]) ||
	((cap_size == `CMSB_SIZE_LONG) && (cap_addr[1:0] != 2'h0));
wire size_bad = (cap_size == 2'h3) ||
	(in_word && (cap_size != `CMSB_SIZE_LONG));
wire next_fault = !(in_word || in_win) ||
	size_bad ||
	misalign ||
	(in_win && upper_off);
wire next_win = in_win;

// byte lane and word index of the current step; the lowest
// channel rides the top lane, so the lane is the inverted
// address low bits
wire [1:0] lane_pos = cap_addr[1:0] + step;
wire [1:0] lane_sel = ~lane_pos;
wire [9:0] ch_off = win_off + {8'h00, step};
wire [GRP_W+9:0] host_idx = cap_win ? {win_grp, ch_off} : cap_addr[GRP_W+11:2];
wire [31:0] host_word = cmem[host_idx];
wire [7:0] lane_byte = cap_data[{lane_sel, 3'b000} +: 8];

// ****************************************
// host cycle state machine
// ****************************************
// answer is held until the synced strobe reads high, so a
// slow host never misses it; faulted cycles skip the steps
always @(posedge clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		state <= ST_IDLE;
		step <= 2'h0;
		last_step <= 2'h0;
		cap_rw <= 1'b1;
		cap_size <= 2'h0;
		cap_addr <= 24'h000000;
		cap_data <= 32'h00000000;
		cap_win <= 1'b0;
		fault <= 1'b0;
		host_data_out <= 32'h00000000;
		host_data_oe <= 1'b0;
		host_ack_n <= 1'b1;
		bus_fault_n <= 1'b1;
	end
	else
	begin
		case (state)
			ST_IDLE:
			begin
				if (!cs_sync)
				begin
					cap_rw <= host_rw;
					cap_size <= host_size;
					cap_addr <= host_addr;
					cap_data <= host_data_in;
					state <= ST_CHECK;
				end
			end
			ST_CHECK:
			begin
				fault <= next_fault;
				cap_win <= next_win;
				step <= 2'h0;
				host_data_out <= 32'h00000000;
				// one step per word, two per half, four per window long
				case (cap_size)
					`CMSB_SIZE_HALF: last_step <= 2'h1;
					`CMSB_SIZE_LONG: last_step <= next_win ? 2'h3 : 2'h0;
					default: last_step <= 2'h0;
				endcase
				state <= next_fault ? ST_RESP : ST_XFER;
			end
			ST_XFER:
			begin
				// reads: whole word, or the low byte onto its own lane
				if (!cap_win && cap_rw)
					host_data_out <= host_word;
				else if (cap_rw)
					host_data_out[{lane_sel, 3'b000} +: 8] <= host_word[7:0];
				if (step == last_step)
					state <= ST_RESP;
				else
					step <= step + 2'h1;
			end
			ST_RESP:
			begin
				// answer stands until the strobe is seen high again
				host_ack_n <= fault;
				bus_fault_n <= !fault;
				host_data_oe <= cap_rw && !fault;
				if (cs_sync)
				begin
					host_ack_n <= 1'b1;
					bus_fault_n <= 1'b1;
					host_data_oe <= 1'b0;
					fault <= 1'b0;
					state <= ST_IDLE;
				end
			end
			default: state <= ST_IDLE;
		endcase
	end
end

// ****************************************
// storage writes, full word or low byte only
// ****************************************
// no reset on the array: contents are unknown until written;
// window writes keep bits 31 to 8 of the word
always @(posedge clk)
begin
	if ((state == ST_XFER) && !cap_rw)
	begin
		if (cap_win)
			cmem[host_idx] <= {host_word[31:8], lane_byte};
		else
			cmem[host_idx] <= cap_data;
	end
end

// ****************************************
// sequencer decode of one connection word
// ****************************************
// word and group rate seen by the sequencer
wire [31:0] seq_word = cmem[seq_index];
wire [1:0] seq_rate = rate_of(group_rate, seq_index[GRP_W+9:10]);
wire [2:0] seq_fn = seq_word[`CMSB_FUNC_HI:`CMSB_FUNC_LO];
wire [9:0] seq_src = seq_word[`CMSB_SRC_HI:`CMSB_SRC_LO];
wire fn_msg = (seq_fn == `CMSB_FUNC_MSG);
wire fn_conn = (seq_fn == `CMSB_FUNC_VAR) || (seq_fn == `CMSB_FUNC_CD);
reg [7:0] msg_shift;

// registered decode on each sequencer request; source
// fields read zero unless the word is a connection
always @(posedge clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		seq_valid <= 1'b0;
		seq_function <= 3'h0;
		seq_connect <= 1'b0;
		seq_msg <= 1'b0;
		seq_src_channel <= 10'h000;
		seq_src_lane <= 2'h0;
	end
	else
	begin
		seq_valid <= seq_req;
		if (seq_req)
		begin
			seq_function <= seq_fn;
			seq_msg <= fn_msg;
			seq_connect <= fn_conn;
			seq_src_channel <= fn_conn ? src_channel(seq_rate, seq_src) : 10'h000;
			seq_src_lane <= fn_conn ? src_lane(seq_rate, seq_src) : 2'h0;
		end
	end
end

// message byte serialiser, most significant bit first
// a new request reloads it even while shifting
always @(posedge clk or negedge arst_n)
begin
	if (!arst_n)
		msg_shift <= 8'h00;
	else if (seq_req)
		msg_shift <= fn_msg ? seq_word[`CMSB_MSG_HI:`CMSB_MSG_LO] : 8'h00;
	else if (seq_bit_en)
		msg_shift <= {msg_shift[6:0], 1'b0};
end

assign seq_msg_bit = msg_shift[7]; // flop output

endmodule // cmsb_core
`default_nettype wire

// *** design/cmsb_regs.vh ***
// constants for the connection word decoder and message byte window
`ifndef CMSB_REGS_VH
`define CMSB_REGS_VH

// ****************************************
// address map
// ****************************************
`define CMSB_WORD_BASE 24'h000000
`define CMSB_WIN_BASE 24'h020000
`define CMSB_WIN_LAST 24'h027FFF

// ****************************************
// connection word fields
// ****************************************
`define CMSB_FUNC_HI 31
`define CMSB_FUNC_LO 29
`define CMSB_SRC_HI 9
`define CMSB_SRC_LO 0
`define CMSB_MSG_HI 7
`define CMSB_MSG_LO 0
`define CMSB_FUNC_MSG 3'h2
`define CMSB_FUNC_VAR 3'h3
`define CMSB_FUNC_CD 3'h4

// ****************************************
// group rate codes and access sizes
// ****************************************
`define CMSB_RATE_8 2'h0
`define CMSB_RATE_16 2'h1
`define CMSB_RATE_32 2'h2
`define CMSB_RATE_65 2'h3
`define CMSB_SIZE_BYTE 2'h0
`define CMSB_SIZE_HALF 2'h1
`define CMSB_SIZE_LONG 2'h2
`define CMSB_RESET_WORD 32'h00000000

`endif

// *** test/cmsb_host.sv ***
// host bus master model for the core
`timescale 1ns/100ps
`default_nettype none
module cmsb_host (
	input wire logic clk,
	input wire logic host_ack_n,
	input wire logic bus_fault_n,
	input wire logic [31:0] host_data_out,
	output logic host_cs_n,
	output logic host_rw,
	output logic [1:0] host_size,
	output logic [23:0] host_addr,
	output logic [31:0] host_data_in
);
	// count of answers that never came or never cleared
	int stalls = 0;
	// bus idle at start
	initial {host_cs_n, host_rw, host_size, host_addr, host_data_in} = {1'b1, 59'h0};
	// one cycle, held until answered, then released
	task automatic cyc(input logic rw, input logic [1:0] sz, input logic [23:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic flt);
		int n;
		begin
			@(negedge clk);
			{host_rw, host_size, host_addr, host_data_in, host_cs_n} = {rw, sz, a, wd, 1'b0};
			for (n = 0; n < 30 && (host_ack_n & bus_fault_n) !== 1'b0; n++)
				@(negedge clk);
			stalls += int'(n == 30);
			{rd, flt} = {host_data_out, !bus_fault_n};
			{host_addr, host_data_in, host_cs_n} = {~a, ~wd, 1'b1};
			for (n = 0; n < 30 && (host_ack_n & bus_fault_n) !== 1'b1; n++)
				@(negedge clk);
			stalls += int'(n == 30);
		end
	endtask
endmodule // cmsb_host
`default_nettype wire

// *** test/cmsb_core_chk.sv ***
// checker for decode and bus answer of the core
`timescale 1ns/100ps
`default_nettype none
`include "cmsb_regs.vh"
module cmsb_core_chk (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic host_cs_n,
	input wire logic host_ack_n,
	input wire logic bus_fault_n,
	input wire logic host_rw,
	input wire logic host_data_oe,
	input wire logic [63:0] group_rate,
	input wire logic seq_req,
	input wire logic [14:0] seq_index,
	input wire logic seq_valid,
	input wire logic [2:0] seq_function,
	input wire logic seq_connect,
	input wire logic seq_msg,
	input wire logic [9:0] seq_src_channel,
	input wire logic [1:0] seq_src_lane
);
	logic [1:0] rate_q;
	logic hit;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// rate of the group last asked for
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			rate_q <= 2'h0;
		else if (seq_req)
			rate_q <= group_rate[{seq_index[14:10], 1'b0} +: 2];
	assign hit = seq_valid && seq_connect;
	msg_code_a: assert property (seq_req |=> seq_valid &&
		seq_msg == (seq_function == `CMSB_FUNC_MSG)) else $error("message flag wrong");
	conn_code_a: assert property (seq_valid |->
		seq_connect == (seq_function inside {`CMSB_FUNC_VAR, `CMSB_FUNC_CD})) else $error("conn");
	idle_src_a: assert property (seq_valid && !seq_connect |->
		{seq_src_channel, seq_src_lane} == 12'h000) else $error("source not zero");
	lane_65_a: assert property (hit && rate_q == `CMSB_RATE_65 |->
		seq_src_lane == 2'h0) else $error("lane at 65");
	range_32_a: assert property (hit && rate_q == `CMSB_RATE_32 |->
		!seq_src_channel[9] && !seq_src_lane[1]) else $error("range at 32");
	range_16_a: assert property (hit && rate_q == `CMSB_RATE_16 |->
		seq_src_channel[9:8] == 2'h0) else $error("range at 16");
	range_8_a: assert property (hit && rate_q == `CMSB_RATE_8 |->
		seq_src_channel[9:7] == 3'h0) else $error("range at 8");
	fault_ends_a: assert property (!bus_fault_n |-> host_ack_n) else $error("fault with ack");
	answer_drop_a: assert property ($rose(host_cs_n) |-> ##[1:4]
		(host_ack_n && bus_fault_n)) else $error("answer held");
	answer_due_a: assert property ($fell(host_cs_n) |-> ##[4:10]
		(!host_ack_n || !bus_fault_n)) else $error("no answer");
	oe_on_read_a: assert property (!host_ack_n |-> host_data_oe == host_rw) else $error("drive wrong");
	oe_with_ack_a: assert property (host_data_oe |-> !host_ack_n) else $error("drive without ack");
endmodule // cmsb_core_chk
bind cmsb_core cmsb_core_chk cmsb_core_chk_i (.*);
`default_nettype wire

// *** test/cmsb_core_bench.sv ***
// self-checking bench for the core
`timescale 1ns/100ps
`default_nettype none
`include "cmsb_regs.vh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_total++; \
	$display("Error %s expected %h seen %h", nm, ex, got); end end
module cmsb_core_bench;
	logic clk = 1'b0, arst_n = 1'b0, seq_req = 1'b0, seq_bit_en = 1'b0, flt;
	logic [14:0] seq_index = 15'h0000, idx;
	logic [63:0] group_rate = 64'h0;
	logic [31:0] rd, d;
	logic [11:0] ex;
	logic [9:0] src, o, m [4];
	logic [4:0] g;
	logic [2:0] fn;
	wire logic host_cs_n, host_rw, host_ack_n, bus_fault_n, host_data_oe;
	wire logic seq_valid, seq_connect, seq_msg, seq_msg_bit;
	wire logic [1:0] host_size, seq_src_lane;
	wire logic [2:0] seq_function;
	wire logic [9:0] seq_src_channel;
	wire logic [23:0] host_addr;
	wire logic [31:0] host_data_in, host_data_out;
	int err_total = 0, cmp_count = 0, cycles = 0;
	cmsb_core #(.GRP_W(5)) cmsb_core_i (.*);
	cmsb_host cmsb_host_i (.*);
	always #4 clk = ~clk;
	// cycle ceiling
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			err_total++;
			final_report();
		end
	end
	// expected {channel, lane} of a connection word
	function automatic logic [11:0] exp_src(input logic [1:0] r, input logic [9:0] s);
		case (r)
			`CMSB_RATE_65: return {s, 2'h0};
			`CMSB_RATE_32: return {1'b0, s[9:1], 1'b0, s[0]};
			`CMSB_RATE_16: return {2'h0, s[9:2], s[1:0]};
			default: return {3'h0, s[9:3], s[1:0]};
		endcase
	endfunction
	// one decode request
	task automatic ask(input logic [14:0] i);
		@(negedge clk);
		{seq_index, seq_req} = {i, 1'b1};
		@(negedge clk);
		seq_req = 1'b0;
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ********
	// tests
	// ********
	initial
	begin
		void'($urandom(2055));
		repeat (10) @(posedge clk);
		@(negedge clk);
		arst_n = 1'b1;
		group_rate = {$urandom, $urandom};
		for (int r = 0; r < 4; r++)
		begin
			g = 5'($urandom);
			group_rate[{g, 1'b0} +: 2] = 2'(r);
			for (int k = 0; k < 4; k++)
			begin
				src = k ? 10'($urandom) : 10'h3FF;
				src[2] = src[2] & (r != 0);
				fn = k == 3 ? 3'h5 : k[0] ? `CMSB_FUNC_VAR : `CMSB_FUNC_CD;
				idx = {g, 10'($urandom)};
				cmsb_host_i.cyc(1'b0, `CMSB_SIZE_LONG, {7'h00, idx, 2'h0}, {fn, 19'h0, src}, rd, flt);
				ask(idx);
				ex = k == 3 ? 12'h000 : exp_src(2'(r), src);
				`CHK("source", ex, {seq_src_channel, seq_src_lane})
				`CHK("connect", k != 3, seq_connect)
				`CHK("function", fn, seq_function)
			end
		end
		$display("decode test done");
		g = 5'($urandom);
		o = {1'b0, 7'($urandom), 2'h0};
		d = $urandom;
		for (int i = 0; i < 4; i++)
		begin
			m[i] = 10'($urandom);
			idx = {g, o + 10'(i)};
			cmsb_host_i.cyc(1'b0, `CMSB_SIZE_LONG, {7'h00, idx, 2'h0},
				{`CMSB_FUNC_MSG, 19'h0, m[i]}, rd, flt);
		end
		cmsb_host_i.cyc(1'b0, `CMSB_SIZE_LONG, `CMSB_WIN_BASE + {g, o}, d, rd, flt);
		for (int i = 0; i < 4; i++)
		begin
			ask({g, o + 10'(i)});
			`CHK("message", 1'b1, seq_msg)
			seq_bit_en = 1'b1;
			for (int b = 7; b >= 0; b--)
			begin
				`CHK("bit", d[8 * (3 - i) + b], seq_msg_bit)
				@(negedge clk);
			end
			seq_bit_en = 1'b0;
		end
		cmsb_host_i.cyc(1'b1, `CMSB_SIZE_LONG, `CMSB_WIN_BASE + {g, o}, 32'h0, rd, flt);
		`CHK("window", d, rd)
		cmsb_host_i.cyc(1'b1, `CMSB_SIZE_BYTE, `CMSB_WIN_BASE + {g, o} + 24'h2, 32'h0, rd, flt);
		`CHK("byte", {16'h0, d[15:8], 8'h0}, rd)
		cmsb_host_i.cyc(1'b1, `CMSB_SIZE_LONG, {7'h00, g, o + 10'h1, 2'h0}, 32'h0, rd, flt);
		`CHK("word", {`CMSB_FUNC_MSG, 19'h0, m[1][9:8], d[23:16]}, rd)
		cmsb_host_i.cyc(1'b1, `CMSB_SIZE_HALF, `CMSB_WIN_BASE + {g, o} + 24'h2, 32'h0, rd, flt);
		`CHK("half", {16'h0, d[15:0]}, rd)
		cmsb_host_i.cyc(1'b0, `CMSB_SIZE_LONG, `CMSB_WIN_BASE + {g, o} + 24'h1, ~d, rd, flt);
		`CHK("misalign", 1'b1, flt)
		cmsb_host_i.cyc(1'b0, `CMSB_SIZE_BYTE, {7'h00, g, o, 2'h0}, ~d, rd, flt);
		`CHK("word size", 1'b1, flt)
		cmsb_host_i.cyc(1'b0, 2'h3, `CMSB_WIN_BASE + {g, o}, ~d, rd, flt);
		`CHK("size", 1'b1, flt)
		cmsb_host_i.cyc(1'b1, `CMSB_SIZE_LONG, `CMSB_WIN_BASE + {g, o}, 32'h0, rd, flt);
		`CHK("kept", d, rd)
		$display("message test done");
		for (int t = 0; t < 4; t++)
		begin
			group_rate[63:62] = 2'(t);
			cmsb_host_i.cyc(1'b1, `CMSB_SIZE_LONG, 24'h027E00, 32'h0, rd, flt);
			`CHK("fault", t == 0, flt)
		end
		cmsb_host_i.cyc(1'b0, `CMSB_SIZE_LONG, 24'h028000, 32'h0, rd, flt);
		`CHK("edge", 1'b1, flt)
		`CHK("stalls", 0, cmsb_host_i.stalls)
		$display("fault test done");
		final_report();
	end
endmodule // cmsb_core_bench
`default_nettype wire
